// File: design/cpl_pin_control.sv
// Our own choices: the AHB-Lite slave port and the address map.
`timescale 1ns/1ps
// Function
// R1 - a status change or fault drives the open-drain alert low for 256 us
// R2 - host port buck mode: select pin high gives 500 mA, low 100 mA
// R3 - boost only while power config bit 5 is set and select pin is high
// R4 - charge only when power config bits 5:4 are 01 and enable pin low
// R5 - input limit is the lower of resistor limit and register bits 2:0
// R6 - thermistor out of window suspends charging and stops boost
// R7 - wake falling edge held low for deglitch time turns switch on
// R8 - no supply, wake low for hold time: switch off for a while, then on
// R9 - the outside must drive the charge enable pin high or low, never float
// R10 - source select high means host port, low means adapter
// R11 - wake, hold and off times are counters with parameter terminal counts
// R12 - alert width from a clock counter; new events never shorten a pulse
module cpl_pin_control
    import cpl_pkg::*;
#(
    parameter int unsigned ALERT_PULSE_CYCLES = ALERT_PULSE_CYC_DEF,
    parameter int unsigned WAKE_DEGLITCH_CYC  = WAKE_DEGLITCH_DEF,
    parameter int unsigned RESET_HOLD_CYC     = RESET_HOLD_DEF,
    parameter int unsigned SWITCH_OFF_CYC     = SWITCH_OFF_DEF
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic      [31:0]  hrdata,
    output logic              hreadyout,
    output logic              hresp,
    input  wire cpl_pins_type pins,
    output cpl_ctrl_type      ctrl,
    output logic              alertOut,
    output logic              alertOe
);

    cpl_pins_type     pinsMeta_r;
    cpl_pins_type     pinsSync_r;
    logic             addrPhase;
    logic             addrHit;
    logic             wrPend_r;
    logic             wrHit_r;
    logic [1:0]       wrIdx_r;
    logic [2:0]       inputSource_r;
    logic [2:0]       inputSource_nxt;
    logic [7:0]       powerConfig_r;
    logic [7:0]       powerConfig_nxt;
    logic             shipCmd;
    logic [31:0]      readValue;
    logic [31:0]      hrdata_r;
    cpl_ctrl_type     ctrl_r;
    cpl_ctrl_type     ctrl_nxt;
    cpl_status_type   status;
    cpl_status_type   statusPrev_r;
    logic             thermFault;
    logic [2:0]       minLimit;
    logic [2:0]       hostLimit;
    cpl_sw_state_type swState_r;
    cpl_sw_state_type swState_nxt;
    logic             wakePrev_r;
    logic             wakeFall;
    logic             wakeArmed_r;
    logic             wakeConsume;
    logic [31:0]      lowCnt_r;
    logic [31:0]      offCnt_r;
    logic             statusEvent;
    logic             pulseActive_r;
    logic             pulseStart;
    logic             pending_r;
    logic [31:0]      pulseCnt_r;

    // every pin crosses two flops before any logic looks at it
    always_ff @(posedge clk) begin
        if (reset) begin
            pinsMeta_r <= PINS_IDLE;
            pinsSync_r <= PINS_IDLE;
        end else begin
            pinsMeta_r <= pins;
            pinsSync_r <= pinsMeta_r;
        end
    end

    // zero wait state slave; hsize ignored, only whole words are used
    assign addrPhase = hsel & htrans[1] & hready;
    assign addrHit   = (haddr[31:4] == 28'h0);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            wrPend_r <= 1'b0;
            wrHit_r  <= 1'b0;
            wrIdx_r  <= 2'h0;
        end else begin
            wrPend_r <= addrPhase & hwrite;
            if (addrPhase) begin
                wrHit_r <= addrHit;
                wrIdx_r <= haddr[IDX_LSB +: 2];
            end
        end
    end

    // next values feed both the flops and a read that follows a write
    always_comb begin
        inputSource_nxt = inputSource_r;
        powerConfig_nxt = powerConfig_r;
        if (wrPend_r && wrHit_r) begin
            if (wrIdx_r == IDX_INPUT_SOURCE) begin
                inputSource_nxt = hwdata[2:0];
            end
            if (wrIdx_r == IDX_POWER_CONFIG) begin
                powerConfig_nxt = hwdata[7:0];
            end
        end
    end

    assign shipCmd = wrPend_r & wrHit_r & (wrIdx_r == IDX_SHIP_CTRL)
                     & hwdata[SHIP_CMD_BIT];

    always_ff @(posedge clk) begin
        if (reset) begin
            inputSource_r <= INPUT_SOURCE_RESET;
            powerConfig_r <= POWER_CONFIG_RESET;
        end else begin
            inputSource_r <= inputSource_nxt;
            powerConfig_r <= powerConfig_nxt;
        end
    end

    always_comb begin
        readValue = 32'h0;
        if (addrHit) begin
            case (haddr[IDX_LSB +: 2])
                IDX_INPUT_SOURCE: readValue = {29'h0, inputSource_nxt};
                IDX_POWER_CONFIG: readValue = {24'h0, powerConfig_nxt};
                IDX_STATUS:       readValue = {22'h0, pulseActive_r,
                                               status};
                default:          readValue = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hrdata_r <= 32'h0;
        end else if (addrPhase && !hwrite) begin
            hrdata_r <= readValue;
        end else begin
            hrdata_r <= 32'h0;
        end
    end

    assign thermFault = pinsSync_r.thermistorSense;

    // codes rise with current, so the lower code is the lower limit
    assign minLimit = (inputSource_r < pinsSync_r.inputLimitSet)
                      ? inputSource_r
                      : pinsSync_r.inputLimitSet;                // [R5]
    assign hostLimit = pinsSync_r.limitSelectBoostEnable
                       ? LIMIT_CODE_500MA
                       : LIMIT_CODE_100MA;                       // [R2]

    always_comb begin
        ctrl_nxt = CTRL_RESET;
        ctrl_nxt.boostActive = powerConfig_r[BOOST_CFG_BIT]
                               & pinsSync_r.limitSelectBoostEnable
                               & ~thermFault;                    // [R3] [R6]
        // a floating enable pin is not filtered here [R9]
        ctrl_nxt.chargeEnable =
            (powerConfig_r[CHG_CFG_HI:CHG_CFG_LO] == CHG_CFG_ON)
            & ~pinsSync_r.chargeEnableN
            & ~thermFault;                                       // [R4] [R6]
        ctrl_nxt.batterySwitch = (swState_r == SW_ON);
        if (!ctrl_nxt.boostActive && pinsSync_r.sourceSelect) begin
            ctrl_nxt.inputCurrentLimit = hostLimit;              // [R10]
        end else begin
            ctrl_nxt.inputCurrentLimit = minLimit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    assign ctrl = ctrl_r;

    // wake pin: an armed falling edge, then a count of low cycles
    assign wakeFall = wakePrev_r & ~pinsSync_r.shipWakeN;

    always_ff @(posedge clk) begin
        if (reset) begin
            wakePrev_r <= 1'b1;
        end else begin
            wakePrev_r <= pinsSync_r.shipWakeN;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wakeArmed_r <= 1'b0;
        end else if (wakeFall) begin
            wakeArmed_r <= 1'b1;
        end else if (pinsSync_r.shipWakeN || wakeConsume) begin
            wakeArmed_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lowCnt_r <= 32'h0;
        end else if (wakeFall) begin
            lowCnt_r <= 32'h1;
        end else if (pinsSync_r.shipWakeN) begin
            lowCnt_r <= 32'h0;
        end else if (wakeArmed_r && lowCnt_r != 32'hFFFFFFFF) begin
            lowCnt_r <= lowCnt_r + 32'h1;                        // [R11]
        end
    end

    // in SW_ON a ship command wins over a wake in the same cycle; SW_SHIP ignores ship commands
    always_comb begin
        swState_nxt = swState_r;
        wakeConsume = 1'b0;
        case (swState_r)
            SW_ON: begin
                if (shipCmd) begin
                    swState_nxt = SW_SHIP;
                end else if (wakeArmed_r && !pinsSync_r.supplyPresent
                             && lowCnt_r >= RESET_HOLD_CYC) begin
                    swState_nxt = SW_RST_OFF;                    // [R8]
                    wakeConsume = 1'b1;
                end
            end
            SW_SHIP: begin
                if (wakeArmed_r && lowCnt_r >= WAKE_DEGLITCH_CYC) begin
                    swState_nxt = SW_ON;                         // [R7]
                    wakeConsume = 1'b1;
                end
            end
            SW_RST_OFF: begin
                if (offCnt_r >= SWITCH_OFF_CYC - 1) begin
                    swState_nxt = SW_ON;                         // [R8]
                end
            end
            default: begin
                swState_nxt = SW_ON;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            swState_r <= SW_ON;
        end else begin
            swState_r <= swState_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            offCnt_r <= 32'h0;
        end else if (swState_r == SW_RST_OFF) begin
            offCnt_r <= offCnt_r + 32'h1;                        // [R11]
        end else begin
            offCnt_r <= 32'h0;
        end
    end

    // any change of the reported state is an event
    assign status.faultIn       = pinsSync_r.faultIn;
    assign status.supplyPresent = pinsSync_r.supplyPresent;
    assign status.thermFault    = thermFault;
    assign status.ctrl          = ctrl_r;

    always_ff @(posedge clk) begin
        if (reset) begin
            statusPrev_r <= '0;
        end else begin
            statusPrev_r <= status;
        end
    end

    assign statusEvent = (status != statusPrev_r);               // [R1]
    assign pulseStart  = (statusEvent | pending_r) & ~pulseActive_r;

    // events during a pulse are folded into one follow-up pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            pending_r <= 1'b0;
        end else begin
            pending_r <= (statusEvent & pulseActive_r)
                         | (pending_r & ~pulseStart);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pulseActive_r <= 1'b0;
            pulseCnt_r    <= 32'h0;
        end else if (pulseStart) begin
            pulseActive_r <= 1'b1;                               // [R1]
            pulseCnt_r    <= 32'h0;
        end else if (pulseActive_r) begin
            if (pulseCnt_r >= ALERT_PULSE_CYCLES - 1) begin
                pulseActive_r <= 1'b0;                           // [R12]
            end else begin
                pulseCnt_r <= pulseCnt_r + 32'h1;
            end
        end
    end

    // open drain: only ever pulls low
    assign alertOut = 1'b0;
    assign alertOe  = pulseActive_r;                             // [R1]

endmodule // cpl_pin_control

// File: design/cpl_pkg.sv
package cpl_pkg;

    // register indices; byte address is four times the index
    localparam logic [1:0] IDX_INPUT_SOURCE = 2'h0;
    localparam logic [1:0] IDX_POWER_CONFIG = 2'h1;
    localparam logic [1:0] IDX_STATUS       = 2'h2;
    localparam logic [1:0] IDX_SHIP_CTRL    = 2'h3;
    localparam int unsigned IDX_LSB         = 2;

    localparam logic [2:0] INPUT_SOURCE_RESET = 3'h2;
    localparam logic [7:0] POWER_CONFIG_RESET = 8'h10;

    localparam int unsigned BOOST_CFG_BIT = 5;
    localparam int unsigned CHG_CFG_HI    = 5;
    localparam int unsigned CHG_CFG_LO    = 4;
    localparam logic [1:0]  CHG_CFG_ON    = 2'h1;
    localparam int unsigned SHIP_CMD_BIT  = 0;

    // limit codes picked by the select pin from a host port
    localparam logic [2:0] LIMIT_CODE_100MA = 3'h0;
    localparam logic [2:0] LIMIT_CODE_500MA = 3'h2;

    localparam int unsigned CLK_MHZ             = 250;
    localparam int unsigned ALERT_PULSE_US      = 256;
    localparam int unsigned ALERT_PULSE_CYC_DEF = ALERT_PULSE_US * CLK_MHZ;
    localparam int unsigned WAKE_DEGLITCH_DEF   = 16;
    localparam int unsigned RESET_HOLD_DEF      = 64;
    localparam int unsigned SWITCH_OFF_DEF      = 32;

    typedef struct packed {
        logic       sourceSelect;
        logic       limitSelectBoostEnable;
        logic       chargeEnableN;
        logic       shipWakeN;
        logic       thermistorSense;
        logic       supplyPresent;
        logic       faultIn;
        logic [2:0] inputLimitSet;
    } cpl_pins_type;

    localparam cpl_pins_type PINS_IDLE = '{
        sourceSelect: 1'b0, limitSelectBoostEnable: 1'b0,
        chargeEnableN: 1'b1, shipWakeN: 1'b1, thermistorSense: 1'b0,
        supplyPresent: 1'b0, faultIn: 1'b0, inputLimitSet: 3'h0};

    typedef struct packed {
        logic       boostActive;
        logic       chargeEnable;
        logic       batterySwitch;
        logic [2:0] inputCurrentLimit;
    } cpl_ctrl_type;

    localparam cpl_ctrl_type CTRL_RESET = '{
        boostActive: 1'b0, chargeEnable: 1'b0,
        batterySwitch: 1'b1, inputCurrentLimit: 3'h0};

    typedef struct packed {
        logic         faultIn;
        logic         supplyPresent;
        logic         thermFault;
        cpl_ctrl_type ctrl;
    } cpl_status_type;

    typedef enum logic [2:0] {
        SW_ON      = 3'b001,
        SW_SHIP    = 3'b010,
        SW_RST_OFF = 3'b100
    } cpl_sw_state_type;

endpackage

// File: tb/cpl_host_model.sv
`timescale 1ns/1ps
module cpl_host_model (
    input  wire logic clk,
    input  wire logic alertOut,
    input  wire logic alertOe,
    input  wire logic chargeReq,
    output logic      chargeEnableN,
    output int        pulseCount,
    output int        lastWidth
);
    logic alertLine;
    int   width_r;

    // host pull-up makes the line high whenever nobody sinks it
    assign alertLine = alertOe ? alertOut : 1'b1;
    assign chargeEnableN = (chargeReq === 1'b1) ? 1'b0 : 1'b1;

    always @(posedge clk) begin
        if (alertLine === 1'b0)
            width_r <= width_r + 1;
        else if (width_r != 0) begin
            pulseCount <= pulseCount + 1;
            lastWidth <= width_r;
            width_r <= 0;
        end
    end
endmodule // cpl_host_model

// File: tb/cpl_pin_control_checker.sv
`timescale 1ns/1ps
module cpl_pin_control_checker
    import cpl_pkg::*;
#(
    parameter int unsigned ALERT_PULSE_CYCLES = ALERT_PULSE_CYC_DEF,
    parameter int unsigned WAKE_DEGLITCH_CYC  = WAKE_DEGLITCH_DEF,
    parameter int unsigned RESET_HOLD_CYC     = RESET_HOLD_DEF,
    parameter int unsigned SWITCH_OFF_CYC     = SWITCH_OFF_DEF
) (
    input wire logic         clk,
    input wire logic         reset,
    input wire cpl_pins_type pins,
    input wire cpl_ctrl_type ctrl,
    input wire logic         alertOut,
    input wire logic         alertOe
);
    int unsigned pulseLen_r;
    int unsigned wakeRun_r;
    logic [2:0]  age_r;
    logic        longRun_r;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // age guards the latency checks until the pin syncs are flushed
    always_ff @(posedge clk) begin
        pulseLen_r <= (reset || !alertOe) ? 0 : pulseLen_r + 1;
        wakeRun_r <= (reset || pins.shipWakeN) ? 0 : wakeRun_r + 1;
        age_r <= reset ? 3'h0 : (age_r[2] ? age_r : age_r + 3'h1);
        longRun_r <= (reset || $rose(ctrl.batterySwitch)) ? 1'b0 :
            (longRun_r || wakeRun_r >= WAKE_DEGLITCH_CYC);
    end

    sequence s_switch_off;
        ##[1:8] !ctrl.batterySwitch;
    endsequence

    property p_alert_len;
        $fell(alertOe) |-> pulseLen_r == ALERT_PULSE_CYCLES;
    endproperty
    property p_alert_cap;
        pulseLen_r <= ALERT_PULSE_CYCLES;
    endproperty
    property p_alert_od;
        alertOe |-> alertOut == 1'b0;
    endproperty
    property p_boost;
        age_r[2] && ctrl.boostActive |->
            $past(pins.limitSelectBoostEnable, 3) &&
            !$past(pins.thermistorSense, 3);
    endproperty
    property p_charge;
        age_r[2] && ctrl.chargeEnable |->
            !$past(pins.chargeEnableN, 3) && !$past(pins.thermistorSense, 3);
    endproperty
    property p_limit_host;
        age_r[2] && $past(pins.sourceSelect, 3) && !ctrl.boostActive |->
            ctrl.inputCurrentLimit == ($past(pins.limitSelectBoostEnable, 3)
            ? LIMIT_CODE_500MA : LIMIT_CODE_100MA);
    endproperty
    property p_limit_min;
        age_r[2] && !$past(pins.sourceSelect, 3) |->
            ctrl.inputCurrentLimit <= $past(pins.inputLimitSet, 3);
    endproperty
    property p_wake;
        $rose(ctrl.batterySwitch) |-> longRun_r;
    endproperty
    property p_rst_off;
        age_r[2] && ctrl.batterySwitch && wakeRun_r == RESET_HOLD_CYC &&
            !pins.supplyPresent && !$past(pins.supplyPresent, 3)
            |-> s_switch_off;
    endproperty

    a_alert_len: assert property (p_alert_len)
        else $error("alert pulse width wrong");
    a_alert_cap: assert property (p_alert_cap)
        else $error("alert pulse too long");
    a_alert_od: assert property (p_alert_od)
        else $error("alert not pulled low");
    a_boost: assert property (p_boost)
        else $error("boost without its conditions");
    a_charge: assert property (p_charge)
        else $error("charge without its conditions");
    a_limit_host: assert property (p_limit_host)
        else $error("host port limit wrong");
    a_limit_min: assert property (p_limit_min)
        else $error("limit above resistor limit");
    a_wake: assert property (p_wake)
        else $error("switch on without deglitched wake");
    a_rst_off: assert property (p_rst_off)
        else $error("switch not reset on long wake");
endmodule // cpl_pin_control_checker

bind cpl_pin_control cpl_pin_control_checker #(
    .ALERT_PULSE_CYCLES(ALERT_PULSE_CYCLES),
    .WAKE_DEGLITCH_CYC (WAKE_DEGLITCH_CYC),
    .RESET_HOLD_CYC    (RESET_HOLD_CYC),
    .SWITCH_OFF_CYC    (SWITCH_OFF_CYC)
) u_cpl_pin_control_checker (.clk(clk), .reset(reset), .pins(pins),
    .ctrl(ctrl), .alertOut(alertOut), .alertOe(alertOe));

// File: tb/cpl_pin_control_tb.sv
`timescale 1ns/1ps
module cpl_pin_control_tb
    import cpl_pkg::*;
;
    localparam int ALERT = 20;
    localparam int OFF = 6;
    logic clk = 1'b0;
    logic reset, hsel, hwrite, hready, hreadyout, hresp;
    logic alertOut, alertOe, chargeReq, hostCeN;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    cpl_pins_type drv, pins;
    cpl_ctrl_type ctrl;
    int failures, checks_done, pulseCount, lastWidth, n0, n;

    assign hready = hreadyout;
    always_comb begin
        pins = drv;
        pins.chargeEnableN = hostCeN;
    end
    always #2 clk = ~clk;

    cpl_pin_control #(.ALERT_PULSE_CYCLES(ALERT), .WAKE_DEGLITCH_CYC(4),
        .RESET_HOLD_CYC(12), .SWITCH_OFF_CYC(OFF)) u_cpl_pin_control (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pins(pins), .ctrl(ctrl), .alertOut(alertOut),
        .alertOe(alertOe));
    cpl_host_model u_cpl_host_model (.clk(clk), .alertOut(alertOut),
        .alertOe(alertOe), .chargeReq(chargeReq), .chargeEnableN(hostCeN),
        .pulseCount(pulseCount), .lastWidth(lastWidth));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [31:0] a, exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
        chk(32'(hresp), 32'h0);
    endtask

    task automatic settle();
        repeat (6) @(posedge clk);
    endtask

    task automatic summarize();
        $display("checks=%0d failures=%0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, chargeReq} = '0;
        {reset, hsize, drv} = {1'b1, 3'h2, PINS_IDLE};
        {failures, checks_done} = '0;
        repeat (3) @(posedge clk);
        chk(32'(ctrl), 32'(CTRL_RESET));
        reset <= 1'b0;
        rd(32'h0, 32'h2);
        rd(32'h4, 32'h10);
        rd(32'h10, 32'h0);
        $display("test registers done");
        @(posedge clk) drv.sourceSelect <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) drv.limitSelectBoostEnable <= i[0];
            settle();
            chk(32'(ctrl.inputCurrentLimit), i ? 32'h2 : 32'h0);
        end
        @(posedge clk) drv.sourceSelect <= 1'b0;
        wr(32'h0, 32'h5);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk) drv.inputLimitSet <= i ? 3'h7 : 3'h3;
            settle();
            chk(32'(ctrl.inputCurrentLimit), i ? 32'h5 : 32'h3);
        end
        $display("test limits done");
        wr(32'h4, 32'h20);
        settle();
        chk(32'(ctrl.boostActive), 32'h1);
        @(posedge clk) drv.thermistorSense <= 1'b1;
        settle();
        chk(32'(ctrl.boostActive), 32'h0);
        wr(32'h4, 32'h10);
        chargeReq <= 1'b1;
        settle();
        chk(32'(ctrl.chargeEnable), 32'h0);
        @(posedge clk) drv.thermistorSense <= 1'b0;
        settle();
        chk(32'(ctrl.chargeEnable), 32'h1);
        wr(32'h4, 32'h30);
        settle();
        chk(32'(ctrl.chargeEnable), 32'h0);
        $display("test boost and charge done");
        repeat (3 * ALERT) @(posedge clk);
        n0 = pulseCount;
        @(posedge clk) drv.faultIn <= 1'b1;
        repeat (3) @(posedge clk);
        drv.faultIn <= 1'b0;
        repeat (3 * ALERT) @(posedge clk);
        chk(32'(pulseCount - n0), 32'h2);
        chk(32'(lastWidth), 32'(ALERT));
        rd(32'h8, 32'h2D);
        $display("test alert done");
        @(posedge clk) drv.supplyPresent <= 1'b1;
        wr(32'hC, 32'h1);
        @(posedge clk) drv.shipWakeN <= 1'b0;
        repeat (2) @(posedge clk);
        drv.shipWakeN <= 1'b1;
        settle();
        chk(32'(ctrl.batterySwitch), 32'h0);
        @(posedge clk) drv.shipWakeN <= 1'b0;
        repeat (10) @(posedge clk);
        drv.shipWakeN <= 1'b1;
        settle();
        chk(32'(ctrl.batterySwitch), 32'h1);
        @(posedge clk) drv.supplyPresent <= 1'b0;
        settle();
        drv.shipWakeN <= 1'b0;
        for (n = 0; ctrl.batterySwitch !== 1'b0 && n < 40; n++)
            @(posedge clk);
        for (n = 0; ctrl.batterySwitch === 1'b0 && n < 40; n++)
            @(posedge clk);
        chk(32'(n), 32'(OFF));
        drv.shipWakeN <= 1'b1;
        $display("test wake done");
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        summarize();
    end
endmodule // cpl_pin_control_tb
